/* File: logic/gp_pin_ctrl.sv */
// One general-purpose pin: mode decode, drive and input sampling
`timescale 1ns/100ps
module gp_pin_ctrl
	import gpio_path_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_in,
	input wire logic local_out_in,
	input wire logic remote_en_in,
	input wire logic remote_val_in,
	input wire logic func_val_in,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe_out,
	output logic level_out
);
	logic out_reg, out_next, oe_reg, oe_next, lvl_reg, lvl_next;

	always_comb begin
		out_next = 1'b0;
		oe_next = 1'b0;
		lvl_next = pad_in;
		case (mode_in)
			PIN_FUNC_OUT: begin
				out_next = func_val_in;
				oe_next = 1'b1;
			end
			// Remote control forces the pin to an output
			PIN_GP_OUT, PIN_GP_IN: begin
				oe_next = remote_en_in || (mode_in == PIN_GP_OUT);
				out_next = remote_en_in ? remote_val_in : local_out_in;
			end
			default: begin
				oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			lvl_reg <= lvl_next;
		end
	end

	assign pad_out = out_reg;
	assign pad_oe_out = oe_reg;
	assign level_out = lvl_reg;
endmodule

/* File: logic/gpio_pair_path_regs.sv */
// Pin pair and video/audio datapath configuration bank with Avalon-MM slave
// Contract
// - Each pin drives its local value only in GP output mode, remote off.
// - Pin setting {direction,enable}: 00 functional, 10 high-Z, 01 GP out, 11 GP in.
// - Second pin uses bits 5 and 4; first pin uses bits 1 and 0.
// - Load-block bit 7 set keeps local values; clear allows forward loading.
// - Datapath bits 6..0 load from the remote serializer unless bit 7 set.
// - Pass-always bit 6 forwards pixels regardless of data enable.
// - Pass-always disables content protection and blocks packetized audio.
// - Invert bit 5 makes data enable active low; clear means active high.
// - Suppress bit 4 keeps packetized audio off the video pins.
// - Quad override bit 3 lets bit 0 set quad audio, else disabled.
// - Bit 2 selects 18-bit video when set, 24-bit when clear.
// - Surround audio withheld in repeater mode with 18-bit video.
// - Bit 1 selects in-band audio transport, else data-island transport.
// - Bit 0 enables quad serial audio when set, only while override bit 3 is also set.
`timescale 1ns/100ps
module gpio_pair_path_regs
	import gpio_path_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	// Avalon-MM slave
	input wire logic [gpio_path_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [gpio_path_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [gpio_path_pkg::DATA_W-1:0] AVS_READDATA_OUT,
	output logic [1:0] AVS_RESPONSE_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Forward channel settings from the remote serializer
	input wire logic FWD_LOAD_VALID_IN,
	input wire logic [6:0] FWD_LOAD_DATA_IN,
	// Remote pin control and functional sources
	input wire logic PIN_A_REMOTE_EN_IN,
	input wire logic PIN_A_REMOTE_VAL_IN,
	input wire logic PIN_A_FUNC_IN,
	input wire logic PIN_B_REMOTE_EN_IN,
	input wire logic PIN_B_REMOTE_VAL_IN,
	input wire logic PIN_B_FUNC_IN,
	// Pin pair pads
	input wire logic PIN_A_IN,
	output logic PIN_A_OUT,
	output logic PIN_A_OE_OUT,
	input wire logic PIN_B_IN,
	output logic PIN_B_OUT,
	output logic PIN_B_OE_OUT,
	// Video path
	input wire logic REPEATER_MODE_IN,
	input wire logic DATA_ENABLE_IN,
	input wire logic [gpio_path_pkg::RGB_W-1:0] RGB_IN,
	output logic [gpio_path_pkg::RGB_W-1:0] RGB_OUT,
	// Feature enables
	output logic CONTENT_PROTECT_EN_OUT,
	output logic PACKET_AUDIO_EN_OUT,
	output logic AUX_ON_VIDEO_OUT,
	output logic QUAD_AUDIO_EN_OUT,
	output logic SURROUND_OK_OUT,
	output logic INBAND_AUDIO_OUT
);
	import gpio_path_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} bus_state_e;

	bus_state_e state_reg, state_next;
	logic [REG_W-1:0] gpio_reg, gpio_next;
	logic [REG_W-1:0] path_reg, path_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [1:0] resp_reg, resp_next;
	logic hit_gpio, hit_path, hit_status, hit_any;
	logic wr_fire, wr_gpio, wr_path, fwd_take;
	logic pin_a_level, pin_b_level;
	logic [REG_W-1:0] status_val;

	path_cfg_if cfg_bus ();

	// Address decode
	always_comb begin
		hit_gpio = (AVS_ADDRESS_IN == ADDR_GPIO_PAIR);
		hit_path = (AVS_ADDRESS_IN == ADDR_PATH_CTRL);
		hit_status = (AVS_ADDRESS_IN == ADDR_PIN_STATUS);
		hit_any = hit_gpio || hit_path || hit_status;
		wr_fire = (state_reg == ST_ACK) && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
		wr_gpio = wr_fire && hit_gpio;
		wr_path = wr_fire && hit_path;
		status_val = {4'h0, SURROUND_OK_OUT, QUAD_AUDIO_EN_OUT, pin_b_level, pin_a_level};
	end

	// One wait state: request taken in idle, answered in ack
	always_comb begin
		state_next = state_reg;
		rdata_next = rdata_reg;
		resp_next = resp_reg;
		case (state_reg)
			ST_IDLE: begin
				if (AVS_READ_IN || AVS_WRITE_IN) begin
					state_next = ST_ACK;
					resp_next = hit_any ? RESP_OKAY : RESP_SLVERR;
					rdata_next = '0;
					if (AVS_READ_IN && hit_gpio) begin
						rdata_next = {24'h000000, gpio_reg};
					end else if (AVS_READ_IN && hit_path) begin
						rdata_next = {24'h000000, path_reg};
					end else if (AVS_READ_IN && hit_status) begin
						rdata_next = {24'h000000, status_val};
					end
				end
			end
			ST_ACK: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= ST_IDLE;
			rdata_reg <= '0;
			resp_reg <= RESP_OKAY;
		end else begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			resp_reg <= resp_next;
		end
	end

	assign AVS_WAITREQUEST_OUT = (state_reg != ST_ACK);
	assign AVS_READDATA_OUT = rdata_reg;
	assign AVS_RESPONSE_OUT = resp_reg;

	// Register contents; a local write beats a forward load in the same cycle
	always_comb begin
		gpio_next = gpio_reg;
		path_next = path_reg;
		if (wr_gpio) begin
			gpio_next = AVS_WRITEDATA_IN[REG_W-1:0];
		end
		fwd_take = FWD_LOAD_VALID_IN && !path_reg[FORWARD_LOAD_BLOCK_BIT] && !wr_path;
		if (wr_path) begin
			path_next = AVS_WRITEDATA_IN[REG_W-1:0];
		end else if (fwd_take) begin
			path_next = {path_reg[FORWARD_LOAD_BLOCK_BIT], FWD_LOAD_DATA_IN};
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			gpio_reg <= GPIO_PAIR_RESET;
			path_reg <= PATH_CTRL_RESET;
		end else begin
			gpio_reg <= gpio_next;
			path_reg <= path_next;
		end
	end

	assign cfg_bus.pass_all = path_reg[PIXEL_PASS_ALWAYS_BIT];
	assign cfg_bus.de_invert = path_reg[DATA_ENABLE_INVERT_BIT];
	assign cfg_bus.audio_suppress = path_reg[AUDIO_ON_VIDEO_SUPPRESS_BIT];
	assign cfg_bus.quad_override = path_reg[QUAD_OVERRIDE_BIT];
	assign cfg_bus.quad_enable = path_reg[QUAD_ENABLE_BIT];
	assign cfg_bus.video_18 = path_reg[VIDEO_18_BIT];
	assign cfg_bus.inband_audio = path_reg[INBAND_AUDIO_BIT];

	gp_pin_ctrl u_pin_a (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.mode_in({gpio_reg[PIN_A_DIRECTION_BIT], gpio_reg[PIN_A_ENABLE_BIT]}),
		.local_out_in(gpio_reg[PIN_A_LOCAL_OUT_BIT]),
		.remote_en_in(PIN_A_REMOTE_EN_IN),
		.remote_val_in(PIN_A_REMOTE_VAL_IN),
		.func_val_in(PIN_A_FUNC_IN),
		.pad_in(PIN_A_IN),
		.pad_out(PIN_A_OUT),
		.pad_oe_out(PIN_A_OE_OUT),
		.level_out(pin_a_level)
	);

	gp_pin_ctrl u_pin_b (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.mode_in({gpio_reg[PIN_B_DIRECTION_BIT], gpio_reg[PIN_B_ENABLE_BIT]}),
		.local_out_in(gpio_reg[PIN_B_LOCAL_OUT_BIT]),
		.remote_en_in(PIN_B_REMOTE_EN_IN),
		.remote_val_in(PIN_B_REMOTE_VAL_IN),
		.func_val_in(PIN_B_FUNC_IN),
		.pad_in(PIN_B_IN),
		.pad_out(PIN_B_OUT),
		.pad_oe_out(PIN_B_OE_OUT),
		.level_out(pin_b_level)
	);

	video_path_ctrl u_path (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.cfg(cfg_bus.path),
		.repeater_in(REPEATER_MODE_IN),
		.de_in(DATA_ENABLE_IN),
		.rgb_in(RGB_IN),
		.rgb_out(RGB_OUT),
		.cp_en_out(CONTENT_PROTECT_EN_OUT),
		.pkt_audio_en_out(PACKET_AUDIO_EN_OUT),
		.aux_on_video_out(AUX_ON_VIDEO_OUT),
		.quad_en_out(QUAD_AUDIO_EN_OUT),
		.surround_ok_out(SURROUND_OK_OUT),
		.inband_out(INBAND_AUDIO_OUT)
	);

	// Checks on the bank and what it steers
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	property p_pin_a_local;
		(gpio_reg[1:0] == PIN_GP_OUT) && !PIN_A_REMOTE_EN_IN
			|=> PIN_A_OE_OUT && (PIN_A_OUT == $past(gpio_reg[PIN_A_LOCAL_OUT_BIT]));
	endproperty
	a_pin_a_local: assert property (p_pin_a_local) else $error("pin a local drive wrong");

	property p_pin_b_local;
		(gpio_reg[5:4] == PIN_GP_OUT) && !PIN_B_REMOTE_EN_IN
			|=> PIN_B_OE_OUT && (PIN_B_OUT == $past(gpio_reg[PIN_B_LOCAL_OUT_BIT]));
	endproperty
	a_pin_b_local: assert property (p_pin_b_local) else $error("pin b local drive wrong");

	property p_pin_modes;
		(gpio_reg[5:4] == PIN_HIGH_Z) || ((gpio_reg[5:4] == PIN_GP_IN) && !PIN_B_REMOTE_EN_IN)
			|=> !PIN_B_OE_OUT;
	endproperty
	a_pin_modes: assert property (p_pin_modes) else $error("pin b drives when it must not");

	property p_pin_func;
		(gpio_reg[1:0] == PIN_FUNC_OUT) |=> PIN_A_OE_OUT && (PIN_A_OUT == $past(PIN_A_FUNC_IN));
	endproperty
	a_pin_func: assert property (p_pin_func) else $error("pin a functional output wrong");

	property p_block_hold;
		path_reg[FORWARD_LOAD_BLOCK_BIT] && !wr_path |=> $stable(path_reg);
	endproperty
	a_block_hold: assert property (p_block_hold) else $error("blocked register changed");

	property p_fwd_load;
		!path_reg[FORWARD_LOAD_BLOCK_BIT] && FWD_LOAD_VALID_IN && !wr_path
			|=> (path_reg[6:0] == $past(FWD_LOAD_DATA_IN)) && !path_reg[FORWARD_LOAD_BLOCK_BIT];
	endproperty
	a_fwd_load: assert property (p_fwd_load) else $error("forward load missed");

	property p_pass_blocks;
		path_reg[PIXEL_PASS_ALWAYS_BIT]
			|=> !CONTENT_PROTECT_EN_OUT && !PACKET_AUDIO_EN_OUT && !AUX_ON_VIDEO_OUT;
	endproperty
	a_pass_blocks: assert property (p_pass_blocks) else $error("pass mode left features on");

	property p_pixel_pass_always;
		path_reg[PIXEL_PASS_ALWAYS_BIT] && !path_reg[VIDEO_18_BIT] |=> RGB_OUT == $past(RGB_IN);
	endproperty
	a_pixel_pass_always: assert property (p_pixel_pass_always) else $error("pixels not passed");

	property p_de_idle;
		!path_reg[PIXEL_PASS_ALWAYS_BIT] && (DATA_ENABLE_IN == path_reg[DATA_ENABLE_INVERT_BIT])
			|=> RGB_OUT == '0;
	endproperty
	a_de_idle: assert property (p_de_idle) else $error("pixels leaked while idle");

	property p_suppress;
		path_reg[AUDIO_ON_VIDEO_SUPPRESS_BIT] |=> !AUX_ON_VIDEO_OUT;
	endproperty
	a_suppress: assert property (p_suppress) else $error("audio placed on video pins");

	property p_quad;
		1'b1 |=> QUAD_AUDIO_EN_OUT == $past(path_reg[QUAD_OVERRIDE_BIT] & path_reg[QUAD_ENABLE_BIT]);
	endproperty
	a_quad: assert property (p_quad) else $error("quad audio enable wrong");

	property p_width;
		path_reg[VIDEO_18_BIT] |=> (RGB_OUT & ~RGB_18_MASK) == '0;
	endproperty
	a_width: assert property (p_width) else $error("low bits kept in narrow video");

	property p_surround;
		REPEATER_MODE_IN && path_reg[VIDEO_18_BIT] |=> !SURROUND_OK_OUT;
	endproperty
	a_surround: assert property (p_surround) else $error("surround offered in repeater");

	property p_transport;
		1'b1 |=> INBAND_AUDIO_OUT == $past(path_reg[INBAND_AUDIO_BIT]);
	endproperty
	a_transport: assert property (p_transport) else $error("transport select wrong");

	property p_quad_en;
		path_reg[QUAD_OVERRIDE_BIT] |=> QUAD_AUDIO_EN_OUT == $past(path_reg[QUAD_ENABLE_BIT]);
	endproperty
	a_quad_en: assert property (p_quad_en) else $error("quad enable ignored");

	property p_reserved;
		wr_gpio |=> gpio_reg == $past(AVS_WRITEDATA_IN[REG_W-1:0]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("pin register write lost");

	property p_bus_answer;
		(state_reg == ST_IDLE) && (AVS_READ_IN || AVS_WRITE_IN)
			|-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

	c_fwd_load: cover property (fwd_take ##1 path_reg[PIXEL_PASS_ALWAYS_BIT]);
	c_block_write: cover property (wr_path && AVS_WRITEDATA_IN[FORWARD_LOAD_BLOCK_BIT]);
	c_unmapped: cover property (!AVS_WAITREQUEST_OUT && (AVS_RESPONSE_OUT == RESP_SLVERR));
	c_pin_b_out: cover property (PIN_B_OE_OUT && PIN_B_OUT);
endmodule

/* File: logic/gpio_path_pkg.sv */
// Shared constants for the pin pair and datapath configuration bank
package gpio_path_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int RGB_W = 24;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GPIO_PAIR = 8'h21;
	localparam logic [7:0] IDX_PATH_CTRL = 8'h22;
	localparam logic [7:0] IDX_PIN_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_GPIO_PAIR = {IDX_GPIO_PAIR, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PATH_CTRL = {IDX_PATH_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS = {IDX_PIN_STATUS, 2'h0};
	localparam logic [REG_W-1:0] GPIO_PAIR_RESET = 8'h00;
	localparam logic [REG_W-1:0] PATH_CTRL_RESET = 8'h00;
	// Pin pair field positions
	localparam int PIN_B_LOCAL_OUT_BIT = 7;
	localparam int PIN_B_DIRECTION_BIT = 5;
	localparam int PIN_B_ENABLE_BIT = 4;
	localparam int PIN_A_LOCAL_OUT_BIT = 3;
	localparam int PIN_A_DIRECTION_BIT = 1;
	localparam int PIN_A_ENABLE_BIT = 0;
	// Datapath field positions
	localparam int FORWARD_LOAD_BLOCK_BIT = 7;
	localparam int PIXEL_PASS_ALWAYS_BIT = 6;
	localparam int DATA_ENABLE_INVERT_BIT = 5;
	localparam int AUDIO_ON_VIDEO_SUPPRESS_BIT = 4;
	localparam int QUAD_OVERRIDE_BIT = 3;
	localparam int VIDEO_18_BIT = 2;
	localparam int INBAND_AUDIO_BIT = 1;
	localparam int QUAD_ENABLE_BIT = 0;
	// Pin setting {direction, enable}
	localparam logic [1:0] PIN_FUNC_OUT = 2'h0;
	localparam logic [1:0] PIN_HIGH_Z = 2'h2;
	localparam logic [1:0] PIN_GP_OUT = 2'h1;
	localparam logic [1:0] PIN_GP_IN = 2'h3;
	localparam logic [RGB_W-1:0] RGB_18_MASK = 24'hFCFCFC;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/path_cfg_if.sv */
// Datapath settings carried from the register bank to the video path
`timescale 1ns/100ps
interface path_cfg_if;
	logic pass_all;
	logic de_invert;
	logic audio_suppress;
	logic quad_override;
	logic video_18;
	logic inband_audio;
	logic quad_enable;
	modport ctrl (output pass_all, de_invert, audio_suppress, quad_override, video_18,
		inband_audio, quad_enable);
	modport path (input pass_all, de_invert, audio_suppress, quad_override, video_18,
		inband_audio, quad_enable);
endinterface

/* File: logic/video_path_ctrl.sv */
// Pixel framing and audio feature enables driven by datapath settings
`timescale 1ns/100ps
module video_path_ctrl
	import gpio_path_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	path_cfg_if.path cfg,
	input wire logic repeater_in,
	input wire logic de_in,
	input wire logic [RGB_W-1:0] rgb_in,
	output logic [RGB_W-1:0] rgb_out,
	output logic cp_en_out,
	output logic pkt_audio_en_out,
	output logic aux_on_video_out,
	output logic quad_en_out,
	output logic surround_ok_out,
	output logic inband_out
);
	logic [RGB_W-1:0] rgb_reg, rgb_next;
	logic [5:0] flag_reg, flag_next;
	logic de_active, quad;

	always_comb begin
		de_active = de_in ^ cfg.de_invert;
		quad = cfg.quad_override & cfg.quad_enable;
		rgb_next = (cfg.pass_all || de_active) ? rgb_in : '0;
		if (cfg.video_18) begin
			rgb_next = rgb_next & RGB_18_MASK;
		end
		flag_next = {!cfg.pass_all, !cfg.pass_all, !cfg.pass_all && !cfg.audio_suppress,
			quad, quad && !(repeater_in && cfg.video_18), cfg.inband_audio};
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rgb_reg <= '0;
			flag_reg <= '0;
		end else begin
			rgb_reg <= rgb_next;
			flag_reg <= flag_next;
		end
	end

	assign rgb_out = rgb_reg;
	assign {cp_en_out, pkt_audio_en_out, aux_on_video_out, quad_en_out, surround_ok_out,
		inband_out} = flag_reg;
endmodule

/* File: sim/fwd_serializer_model.sv */
// Remote serializer model that pushes datapath settings down the forward channel
`timescale 1ns/100ps
module fwd_serializer_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic send_in,
	input wire logic [6:0] data_in,
	output logic valid_out,
	output logic [6:0] data_out
);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			valid_out <= 1'b0;
			data_out <= 7'h55;
		end else if (send_in) begin
			valid_out <= 1'b1;
			data_out <= data_in;
		end else begin
			valid_out <= 1'b0;
			// Idle lines carry junk so a stale value never looks valid
			data_out <= ~data_out;
		end
	end
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the pin pair and datapath configuration bank
`timescale 1ns/100ps
module tb;
	import gpio_path_pkg::*;
	logic clk, rst, rd_en, wr_en, fsend, fvalid;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [3:0] ben;
	logic [1:0] resp, rs;
	logic wait_req;
	logic [6:0] fdata, fwd_data;
	logic a_ren, a_rv, a_fn, b_ren, b_rv, b_fn, ext_a, ext_b, rep, dena;
	logic a_out, a_oe, b_out, b_oe, cp, pa, aux, quad, surr, inb;
	logic [RGB_W-1:0] rgb, rgb_o;
	logic [15:0] lfsr_state, r;
	logic [7:0] v;
	logic [1:0] ea, eb;
	logic [29:0] pe;
	int failures, samples_checked;

	gpio_pair_path_regs dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata),
		.AVS_BYTEENABLE_IN(ben), .AVS_READDATA_OUT(rdata), .AVS_RESPONSE_OUT(resp),
		.AVS_WAITREQUEST_OUT(wait_req), .FWD_LOAD_VALID_IN(fvalid), .FWD_LOAD_DATA_IN(fwd_data),
		.PIN_A_REMOTE_EN_IN(a_ren), .PIN_A_REMOTE_VAL_IN(a_rv), .PIN_A_FUNC_IN(a_fn),
		.PIN_B_REMOTE_EN_IN(b_ren), .PIN_B_REMOTE_VAL_IN(b_rv), .PIN_B_FUNC_IN(b_fn),
		.PIN_A_IN(a_oe ? a_out : ext_a), .PIN_A_OUT(a_out), .PIN_A_OE_OUT(a_oe),
		.PIN_B_IN(b_oe ? b_out : ext_b), .PIN_B_OUT(b_out), .PIN_B_OE_OUT(b_oe),
		.REPEATER_MODE_IN(rep), .DATA_ENABLE_IN(dena), .RGB_IN(rgb), .RGB_OUT(rgb_o),
		.CONTENT_PROTECT_EN_OUT(cp), .PACKET_AUDIO_EN_OUT(pa), .AUX_ON_VIDEO_OUT(aux),
		.QUAD_AUDIO_EN_OUT(quad), .SURROUND_OK_OUT(surr), .INBAND_AUDIO_OUT(inb));

	fwd_serializer_model serializer (.clk_in(clk), .rst_in(rst), .send_in(fsend),
		.data_in(fdata), .valid_out(fvalid), .data_out(fwd_data));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Pad expectation as {enable, value}; value only meaningful while driven
	function automatic logic [1:0] pin_exp(input logic [1:0] m, input logic lo, re, rv, fv);
		case (m)
			PIN_FUNC_OUT: return {1'b1, fv};
			PIN_HIGH_Z: return 2'h0;
			PIN_GP_OUT: return {1'b1, re ? rv : lo};
			default: return {re, re & rv};
		endcase
	endfunction

	function automatic logic [29:0] path_exp(input logic [7:0] c, input logic rp, dn,
		input logic [23:0] px);
		logic q;
		logic [23:0] o;
		q = c[QUAD_OVERRIDE_BIT] & c[QUAD_ENABLE_BIT];
		o = (c[PIXEL_PASS_ALWAYS_BIT] | (dn ^ c[DATA_ENABLE_INVERT_BIT])) ? px : 24'h0;
		if (c[VIDEO_18_BIT])
			o = o & RGB_18_MASK;
		return {o, !c[PIXEL_PASS_ALWAYS_BIT], !c[PIXEL_PASS_ALWAYS_BIT],
			!c[PIXEL_PASS_ALWAYS_BIT] & !c[AUDIO_ON_VIDEO_SUPPRESS_BIT], q,
			q & !(rp & c[VIDEO_18_BIT]), c[INBAND_AUDIO_BIT]};
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Wide enough for response code plus read data
	task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rnd(output logic [15:0] o);
		lfsr_state = lfsr_step(lfsr_state);
		o = lfsr_state;
	endtask

	// Waits for waitrequest low under a bound, then releases after that edge
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
		int n;
		n = 0;
		addr <= a;
		wdata <= wd;
		ben <= be;
		rd_en <= !wr;
		wr_en <= wr;
		@(posedge clk);
		while (wait_req !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk);
		end
		rd = rdata;
		rsp = resp;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n >= 50) begin
			failures++;
			$display("BAD waitrequest expected 0 seen %b", wait_req);
			test_done();
		end
		@(posedge clk);
	endtask

	task automatic shake();
		logic [15:0] s, t;
		rnd(s);
		rnd(t);
		{a_ren, a_rv, a_fn, b_ren, b_rv, b_fn, ext_a, ext_b, rep, dena} <= s[9:0];
		rgb <= {s[15:8], t};
	endtask

	task automatic fwd(input logic [6:0] fd);
		fsend <= 1'b1;
		fdata <= fd;
		@(posedge clk);
		fsend <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		failures = 0;
		samples_checked = 0;
		lfsr_state = 16'h002B;
		rst = 1'b1;
		{rd_en, wr_en, fsend, a_ren, a_rv, a_fn, b_ren, b_rv, b_fn} = '0;
		{ext_a, ext_b, rep, dena} = '0;
		addr = '0;
		wdata = '0;
		ben = 4'hF;
		fdata = 7'h00;
		rgb = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, ADDR_GPIO_PAIR, 32'h0, 4'hF, d, rs);
		chk("pin reg reset", {24'h0, GPIO_PAIR_RESET}, d);
		bus(1'b0, ADDR_PATH_CTRL, 32'h0, 4'hF, d, rs);
		chk("path reg reset", {24'h0, PATH_CTRL_RESET}, d);
		bus(1'b0, 10'h3FC, 32'h0, 4'hF, d, rs);
		chk("unmapped read", {RESP_SLVERR, 32'h0}, {rs, d});
		$display("test reset and map done");
		for (int i = 0; i < 16; i++) begin
			rnd(r);
			v = r[7:0];
			if (i < 4)
				v = {v[7:6], i[1:0], v[3:2], i[1:0]};
			shake();
			bus(1'b1, ADDR_GPIO_PAIR, {r[15:8], 16'h0, v}, 4'hF, d, rs);
			bus(1'b0, ADDR_GPIO_PAIR, 32'h0, 4'hF, d, rs);
			chk("pin reg readback", {RESP_OKAY, 24'h0, v}, {rs, d});
			repeat (3) @(posedge clk);
			ea = pin_exp({v[PIN_A_DIRECTION_BIT], v[PIN_A_ENABLE_BIT]}, v[PIN_A_LOCAL_OUT_BIT],
				a_ren, a_rv, a_fn);
			eb = pin_exp({v[PIN_B_DIRECTION_BIT], v[PIN_B_ENABLE_BIT]}, v[PIN_B_LOCAL_OUT_BIT],
				b_ren, b_rv, b_fn);
			chk("pin a", ea, {a_oe, a_oe & a_out});
			chk("pin b", eb, {b_oe, b_oe & b_out});
			bus(1'b0, ADDR_PIN_STATUS, 32'h0, 4'hF, d, rs);
			chk("pin status", {RESP_OKAY, 30'h0, eb[1] ? eb[0] : ext_b, ea[1] ? ea[0] : ext_a},
				{rs, d});
		end
		bus(1'b1, ADDR_GPIO_PAIR, 32'h0000_00FF, 4'hE, d, rs);
		bus(1'b1, 10'h3F0, 32'h0000_00FF, 4'hF, d, rs);
		chk("unmapped write", {RESP_SLVERR, 32'h0}, {rs, d});
		bus(1'b0, ADDR_GPIO_PAIR, 32'h0, 4'hF, d, rs);
		chk("pin reg after ignored writes", {24'h0, v}, d);
		$display("test pins done");
		for (int i = 0; i < 20; i++) begin
			rnd(r);
			v = r[7:0] | 8'h80;
			if (i == 0)
				v = 8'h8D;
			if (i == 1)
				v = 8'hC0;
			shake();
			bus(1'b1, ADDR_PATH_CTRL, {24'h0, v}, 4'hF, d, rs);
			// Repeater forced on in step 0 over the random shake so setting 8D checks surround withheld in repeater mode
			if (i == 0)
				rep <= 1'b1;
			bus(1'b0, ADDR_PATH_CTRL, 32'h0, 4'hF, d, rs);
			chk("path reg readback", {24'h0, v}, d);
			repeat (3) @(posedge clk);
			pe = path_exp(v, rep, dena, rgb);
			chk("path outputs", pe,
				{rgb_o, cp, pa, aux, quad, surr, inb});
			bus(1'b0, ADDR_PIN_STATUS, 32'h0, 4'hF, d, rs);
			chk("status audio", {30'h0, pe[1], pe[2]}, {30'h0, d[3:2]});
		end
		$display("test datapath done");
		bus(1'b1, ADDR_PATH_CTRL, 32'h0, 4'hF, d, rs);
		for (int i = 0; i < 6; i++) begin
			rnd(r);
			fwd(r[6:0]);
			bus(1'b0, ADDR_PATH_CTRL, 32'h0, 4'hF, d, rs);
			chk("forward load", {25'h0, r[6:0]}, d);
		end
		bus(1'b1, ADDR_PATH_CTRL, 32'h0000_0093, 4'hF, d, rs);
		fwd(7'h6C);
		bus(1'b0, ADDR_PATH_CTRL, 32'h0, 4'hF, d, rs);
		chk("forward load blocked", 32'h0000_0093, d);
		$display("test forward channel done");
		test_done();
	end
endmodule
